// >>> design/prox_regs_pkg.sv
// Notes on behaviour
// - Bits 3:0 of the third emitter register pick the third emitter sink current.
// - Drive code 0000 means no current, 0001 minimum, 1111 maximum current.
// - First threshold is 16 bits, low byte 0x11, high byte 0x12, compared autonomously.
// - Second threshold is 16 bits, low byte 0x13, compared with second-channel results.
// - Every register in this slice resets to all zeros.
// - A half-rewritten threshold may be used by a measurement already running.
// - Older sequencers read the first threshold as one compressed byte at 0x11.
// - Older sequencers read the second threshold as one compressed byte at 0x13.
package prox_regs_pkg;

  // Register offsets on the internal register port.
  localparam logic [7:0] OFS_THIRD_EMITTER_CURRENT = 8'h10;
  localparam logic [7:0] OFS_PROXIMITY1_THRESHOLD_LOW = 8'h11;
  localparam logic [7:0] OFS_PROXIMITY1_THRESHOLD_HIGH = 8'h12;
  localparam logic [7:0] OFS_PROXIMITY2_THRESHOLD_LOW = 8'h13;

  // Field layout and reset values.
  localparam int DRIVE_LSB = 0;
  localparam int DRIVE_MSB = 3;
  localparam logic [3:0] DRIVE_OFF = 4'h0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Compressed threshold layout: exponent in the high nibble, mantissa in the low one.
  localparam int CMP_EXP_LSB = 4;
  localparam int CMP_MAN_MSB = 3;
  localparam logic [3:0] CMP_EXP_SAT = 4'hC;
  localparam logic [15:0] CMP_SAT_VALUE = 16'hFFFF;

  // One register access from the serial bus front end.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // One finished proximity measurement.
  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } prox_result_s;

  // Expands a compressed threshold byte to the 16-bit measurement scale.
  function automatic logic [15:0] expand_threshold(input logic [7:0] c);
    logic [3:0] e;
    logic [19:0] wide;
    e = c[7:CMP_EXP_LSB];
    wide = 20'({1'h1, c[CMP_MAN_MSB:0]}) << (e - 4'h1);
    if (e == 4'h0) begin
      expand_threshold = {12'h000, c[CMP_MAN_MSB:0]};
    end else if (e > CMP_EXP_SAT) begin
      expand_threshold = CMP_SAT_VALUE;
    end else begin
      expand_threshold = wide[15:0];
    end
  endfunction : expand_threshold

endpackage : prox_regs_pkg

// >>> design/threshold_compare.sv
// Compares each finished proximity result with its threshold during an autonomous run and flags a crossing.
module threshold_compare
  import prox_regs_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Threshold source
  input wire logic [15:0] threshold_word,
  input wire logic compressed_mode,
  input wire logic autonomous_run,
  // Measurement and result
  input wire prox_result_s result,
  output logic cross_q
);

  logic [15:0] limit;
  logic cross_d;

  // The live register bytes are used with no shadow copy, so a half-written
  // threshold can meet a measurement already in flight; hardware cost traded
  // for host discipline.
  assign limit = compressed_mode ? expand_threshold(threshold_word[7:0])
                                 : threshold_word;
  assign cross_d = autonomous_run && result.valid && (result.value > limit);

  // A crossing is a one-cycle pulse a cycle after the result arrives.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cross_q <= 1'h0;
    end else begin
      cross_q <= cross_d;
    end
  end

endmodule : threshold_compare

// >>> design/proximity_threshold_third_emitter_sink_pin_regs.sv
// Emitter drive and proximity threshold registers with their threshold compare.
module proximity_threshold_third_emitter_sink_pin_regs
  import prox_regs_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port from the serial bus front end
  input wire reg_req_s reg_req,
  output logic [7:0] reg_rdata_q,
  // Sequencer state
  input wire logic autonomous_run,
  input wire logic compressed_mode,
  input wire logic emitter_pulse,
  input wire logic [7:0] second_threshold_high,
  // Measurement results
  input wire prox_result_s proximity1_result,
  input wire prox_result_s proximity2_result,
  // Emitter drive
  output logic [3:0] third_emitter_drive_level,
  output logic third_emitter_sink_pin_en,
  // Threshold events
  output logic proximity1_cross,
  output logic proximity2_cross
);

  logic [3:0] third_emitter_drive_level_q;
  logic [7:0] proximity1_threshold_low_q;
  logic [7:0] proximity1_threshold_high_q;
  logic [7:0] proximity2_threshold_low_q;
  logic [7:0] reg_rdata_d;
  logic sel_led;
  logic sel_p1_low;
  logic sel_p1_high;
  logic sel_p2_low;
  logic [15:0] first_proximity_threshold;
  logic [15:0] second_proximity_threshold;

  // Address decode; unmapped offsets read zero and swallow writes.
  assign sel_led = reg_req.addr == OFS_THIRD_EMITTER_CURRENT;
  assign sel_p1_low = reg_req.addr == OFS_PROXIMITY1_THRESHOLD_LOW;
  assign sel_p1_high = reg_req.addr == OFS_PROXIMITY1_THRESHOLD_HIGH;
  assign sel_p2_low = reg_req.addr == OFS_PROXIMITY2_THRESHOLD_LOW;

  // Register writes; only the drive field of the emitter register is stored.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      third_emitter_drive_level_q <= REG_RESET[DRIVE_MSB:DRIVE_LSB];
      proximity1_threshold_low_q <= REG_RESET;
      proximity1_threshold_high_q <= REG_RESET;
      proximity2_threshold_low_q <= REG_RESET;
    end else if (reg_req.wr) begin
      if (sel_led) begin
        third_emitter_drive_level_q <= reg_req.wdata[DRIVE_MSB:DRIVE_LSB];
      end
      if (sel_p1_low) begin
        proximity1_threshold_low_q <= reg_req.wdata;
      end
      if (sel_p1_high) begin
        proximity1_threshold_high_q <= reg_req.wdata;
      end
      if (sel_p2_low) begin
        proximity2_threshold_low_q <= reg_req.wdata;
      end
    end
  end

  // Read mux; the reserved nibble above the drive field always reads zero.
  always_comb begin
    reg_rdata_d = READ_ZERO;
    if (sel_led) begin
      reg_rdata_d = {4'h0, third_emitter_drive_level_q};
    end else if (sel_p1_low) begin
      reg_rdata_d = proximity1_threshold_low_q;
    end else if (sel_p1_high) begin
      reg_rdata_d = proximity1_threshold_high_q;
    end else if (sel_p2_low) begin
      reg_rdata_d = proximity2_threshold_low_q;
    end
  end

  // Read data is registered so the bus front end sees a steady byte.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      reg_rdata_q <= REG_RESET;
    end else if (reg_req.rd) begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // Drive code goes straight to the driver; code zero keeps the sink off
  // even while the sequencer is pulsing.
  assign third_emitter_drive_level = third_emitter_drive_level_q;
  assign third_emitter_sink_pin_en = emitter_pulse && (third_emitter_drive_level_q != DRIVE_OFF);

  // Threshold words; the second high byte lives outside this slice.
  assign first_proximity_threshold = {proximity1_threshold_high_q, proximity1_threshold_low_q};
  assign second_proximity_threshold = {second_threshold_high, proximity2_threshold_low_q};

  // First channel compare.
  threshold_compare first_cmp (
    .clock(clock),
    .nrst(nrst),
    .threshold_word(first_proximity_threshold),
    .compressed_mode(compressed_mode),
    .autonomous_run(autonomous_run),
    .result(proximity1_result),
    .cross_q(proximity1_cross)
  );

  // Second channel compare.
  threshold_compare second_cmp (
    .clock(clock),
    .nrst(nrst),
    .threshold_word(second_proximity_threshold),
    .compressed_mode(compressed_mode),
    .autonomous_run(autonomous_run),
    .result(proximity2_result),
    .cross_q(proximity2_cross)
  );

endmodule : proximity_threshold_third_emitter_sink_pin_regs

// >>> tb/host_model.sv
module host_model
  import prox_regs_pkg::*;
(
  // Clock and read data
  input wire logic clock,
  input wire logic [7:0] reg_rdata_q,
  // Register requests
  output reg_req_s reg_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial reg_req = '0;
  // One-cycle strobe; read data is taken one cycle after the strobe edge.
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clock) #1 reg_req = {w, !w, a, d};
    @(posedge clock) #1 reg_req = '0;
    q = reg_rdata_q;
  endtask : acc
endmodule : host_model

// >>> tb/prox_regs_props.sv
module prox_regs_props
  import prox_regs_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Watched ports
  input wire reg_req_s reg_req,
  input wire logic [7:0] reg_rdata_q,
  input wire logic autonomous_run,
  input wire logic emitter_pulse,
  input wire prox_result_s proximity1_result,
  input wire prox_result_s proximity2_result,
  input wire logic [3:0] third_emitter_drive_level,
  input wire logic third_emitter_sink_pin_en,
  input wire logic proximity1_cross,
  input wire logic proximity2_cross
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Decoded emitter register write, shared by several properties.
  wire drive_wr = reg_req.wr && reg_req.addr == OFS_THIRD_EMITTER_CURRENT;
  sink_follow_a: assert property (
    third_emitter_sink_pin_en == (emitter_pulse && |third_emitter_drive_level))
    else $error("Sink enable wrong.");
  reset_clear_a: assert property (disable iff (1'b0)
    !nrst |=> third_emitter_drive_level == 4'h0 && !proximity1_cross && !proximity2_cross)
    else $error("Reset did not clear.");
  drive_load_a: assert property (
    drive_wr |=> third_emitter_drive_level == $past(reg_req.wdata[3:0]))
    else $error("Drive code not loaded.");
  drive_keep_a: assert property (!drive_wr |=> $stable(third_emitter_drive_level))
    else $error("Drive code changed.");
  rsvd_zero_a: assert property (reg_req.rd && reg_req.addr == OFS_THIRD_EMITTER_CURRENT
    |=> reg_rdata_q[7:4] == 4'h0) else $error("Reserved bits not zero.");
  rdata_keep_a: assert property (!reg_req.rd |=> $stable(reg_rdata_q))
    else $error("Read data moved.");
  cross1_gate_a: assert property (proximity1_cross
    |-> $past(autonomous_run && proximity1_result.valid)) else $error("Stray cross 1.");
  cross2_gate_a: assert property (proximity2_cross
    |-> $past(autonomous_run && proximity2_result.valid)) else $error("Stray cross 2.");
  cover property (drive_wr);
  cover property (proximity1_cross);
  cover property (proximity2_cross);
endmodule : prox_regs_props

// >>> tb/tb.sv
module tb;
  import prox_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, nrst = 0, run = 0, cmp = 0, pulse = 0, sink, x1, x2;
  logic [7:0] th2_high = 8'h00, q, rdata;
  logic [3:0] lvl;
  reg_req_s req;
  prox_result_s r1 = '0, r2 = '0;
  int mismatches = 0, samples_checked = 0;
  // Clock at 100 MHz.
  always #5 clock = ~clock;
  host_model u_host(.clock(clock), .reg_rdata_q(rdata), .reg_req(req));
  proximity_threshold_third_emitter_sink_pin_regs u_dut(.clock(clock), .nrst(nrst), .reg_req(req),
    .reg_rdata_q(rdata), .autonomous_run(run), .compressed_mode(cmp), .emitter_pulse(pulse),
    .second_threshold_high(th2_high), .proximity1_result(r1), .proximity2_result(r2),
    .third_emitter_drive_level(lvl), .third_emitter_sink_pin_en(sink),
    .proximity1_cross(x1), .proximity2_cross(x2));
  task automatic chk(input string n, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, e);
    u_host.acc(1'b0, a, 8'h00, q);
    chk("read", q, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, d);
    u_host.acc(1'b1, a, d, q);
  endtask : wr
  // Both channels report at once; crossings show one cycle after the result edge.
  task automatic res(input logic [15:0] v1, v2, input logic e1, e2);
    @(posedge clock) #1 r1 = {1'b1, v1};
    r2 = {1'b1, v2};
    @(posedge clock) #1 r1 = '0;
    r2 = '0;
    chk("cross1", x1, e1);
    chk("cross2", x2, e2);
  endtask : res
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // Test sequence; thresholds are only rewritten while measuring is paused, except the two torn cases.
  initial begin
    repeat (16) @(posedge clock);
    #1 nrst = 1;
    for (int a = 16; a < 20; a++) rd(8'(a), 8'h00);
    wr(8'h10, 8'hA5);
    rd(8'h10, 8'h05);
    chk("drive", lvl, 4'h5);
    pulse = 1;
    #1 chk("sink", sink, 1'b1);
    wr(8'h10, 8'h00);
    chk("sink_off", sink, 1'b0);
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'h00);
    $display("Test registers done");
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h01);
    wr(8'h13, 8'h80);
    rd(8'h12, 8'h01);
    rd(8'h13, 8'h80);
    res(16'h0101, 16'h0081, 1'b0, 1'b0);
    run = 1;
    res(16'h0101, 16'h0081, 1'b1, 1'b1);
    res(16'h0100, 16'h0080, 1'b0, 1'b0);
    wr(8'h11, 8'hFF);
    res(16'h0150, 16'h0081, 1'b0, 1'b1);
    th2_high = 8'h01;
    res(16'h0200, 16'h0180, 1'b1, 1'b0);
    $display("Test compare done");
    run = 0;
    cmp = 1;
    wr(8'h11, 8'h05);
    wr(8'h13, 8'h03);
    run = 1;
    res(16'h0006, 16'h0003, 1'b1, 1'b0);
    res(16'h0005, 16'h0004, 1'b0, 1'b1);
    // Nonzero exponent expands to 0x0022; an exponent above twelve saturates.
    run = 0;
    wr(8'h11, 8'h21);
    wr(8'h13, 8'hD0);
    run = 1;
    res(16'h0023, 16'hFFFF, 1'b1, 1'b0);
    res(16'h0022, 16'hFFFF, 1'b0, 1'b0);
    $display("Test compressed done");
    // Reset in mid-run must clear every byte that was written above.
    wr(8'h10, 8'h0F);
    chk("sink_max", sink, 1'b1);
    @(posedge clock) #1 nrst = 0;
    repeat (2) @(posedge clock);
    #1 nrst = 1;
    chk("drive_rst", lvl, 4'h0);
    for (int a = 16; a < 20; a++) rd(8'(a), 8'h00);
    res(16'h0001, 16'h0000, 1'b1, 1'b0);
    $display("Test reset done");
    end_sim;
  end
  // Cut a hang short; the sequence needs well under 1000 cycles.
  initial begin
    #20000;
    mismatches++;
    end_sim;
  end
endmodule : tb
bind proximity_threshold_third_emitter_sink_pin_regs prox_regs_props u_props(.clock(clock), .nrst(nrst),
  .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .autonomous_run(autonomous_run),
  .emitter_pulse(emitter_pulse), .proximity1_result(proximity1_result),
  .proximity2_result(proximity2_result), .third_emitter_drive_level(third_emitter_drive_level),
  .third_emitter_sink_pin_en(third_emitter_sink_pin_en),
  .proximity1_cross(proximity1_cross), .proximity2_cross(proximity2_cross));
